// ===== bench/serial_dac_model.sv
// receiving model of the serial stereo converter on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module serial_dac_model (
   // serial link from the block
   input wire logic bclk_in,
   input wire logic lr_in,
   input wire logic main_in,
   input wire logic fx_in
);
   logic [63:0] main_sh = 64'h0;
   logic [63:0] fx_sh = 64'h0;
   logic [63:0] lr_sh = 64'h0;
   int nbits = 0;

   // forget the last frame; called between frames, before the next rising bit clock edge
   task automatic clear();
      main_sh = 64'h0;
      fx_sh = 64'h0;
      lr_sh = 64'h0;
      nbits = 0;
   endtask : clear

   // both streams share one bit and word clock; bits are taken on the rising edge only
   always @(posedge bclk_in) begin
      main_sh <= {main_sh[62:0], main_in};
      fx_sh <= {fx_sh[62:0], fx_in};
      lr_sh <= {lr_sh[62:0], lr_in};
      nbits <= nbits + 1;
   end
endmodule : serial_dac_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the serial audio output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import synth_audio_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic fmt = 1'b1;
   logic [5:0] slots = 6'h10;
   logic valid = 1'b0;
   logic [79:0] data = 80'h0;
   wire logic ready, bclk, lrclk, main_d, fx_d, qclk, gclk;
   wire logic [4:0] slot_no;
   int errors = 0;
   int checks_done = 0;
   integer seed = 32'h9fd5561c;
   logic [79:0] sets [0:8];
   int cs [8] = '{16, 16, 18, 20, 24, 30, 32, 32};  // even slot counts only
   logic [7:0] cf = 8'h91;

   // ****************************************
   // design and far side
   // ****************************************
   synth_serial_audio_out uut (
      .REF_CLK_IN(clk), .SRST_IN(srst), .SERIAL_FORMAT_SELECT_IN(fmt), .SLOT_COUNT_IN(slots),
      .SAMPLE_VALID_IN(valid), .SAMPLE_READY_OUT(ready), .MAIN_LEFT_IN(data[79:60]),
      .MAIN_RIGHT_IN(data[59:40]), .EFFECTS_LEFT_IN(data[39:20]), .EFFECTS_RIGHT_IN(data[19:0]),
      .SERIAL_BIT_CLOCK_OUT(bclk), .LR_WORD_CLOCK_OUT(lrclk), .MAIN_AUDIO_OUT(main_d),
      .EFFECTS_AUDIO_OUT(fx_d), .QUARTER_RATE_CLOCK_OUT(qclk), .GATED_EFFECTS_CLOCK_OUT(gclk),
      .CURRENT_SLOT_OUT(slot_no));
   serial_dac_model dac (.bclk_in(bclk), .lr_in(lrclk), .main_in(main_d), .fx_in(fx_d));

   // 50 MHz oscillator
   initial begin
      forever #10 clk = ~clk;
   end

   // ****************************************
   // expectations
   // ****************************************
   // serial image of one frame: data bits (kind 0) or word clock levels (kind 1)
   function automatic logic [63:0] exp_bits(input logic [79:0] st, input int hi, input int kind);
      logic [63:0] v;
      logic [19:0] smp;
      logic b;
      int s, w, j;
      v = 64'h0;
      s = int'(slots);
      w = (fmt || s == 16) ? 16 : ((s == 18) ? 18 : 20);
      for (int k = 0; k < 2 * s; k++) begin
         smp = (k < s) ? st[hi -: 20] : st[hi - 20 -: 20];
         j = (k < s) ? k : k - s;
         b = 1'b0;
         if (kind == 1) b = fmt ? (k >= s) : (k >= s - 1 && k < 2 * s - 1);
         else if (j < w) b = smp[19 - j];  // surplus positions stay zero
         v = {v[62:0], b};
      end
      return v;
   endfunction : exp_bits

   // printed slot number at frame position p; extra pairs follow slots 7 and 15
   function automatic int slot_num(input int p, input int s);
      int e;
      e = (s - 16) / 2;
      if (p < 8) return p;
      if (p < 8 + e) return p + 8;
      if (p < 16 + e) return p - e;
      return p + 8 - e;
   endfunction : slot_num

   // ****************************************
   // tasks
   // ****************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // reset with a new configuration; returns at the falling edge that releases it
   task automatic do_reset(input logic f, input int s, input int n);
      @(negedge clk);
      srst = 1'b1;  // held several cycles so the oscillator has settled
      fmt = f;
      slots = 6'(s);
      repeat (n) @(negedge clk);
      #1;
      `CHK("idle in reset", {qclk, bclk, lrclk, main_d, fx_d}, 5'h0)
      `CHK("gated clock in reset", gclk, 1'b1)
      @(negedge clk);
      srst = 1'b0;
   endtask : do_reset

   // offers sets back to back, holding each until the fifo takes it
   task automatic push_all(input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         data = sets[i];
         valid = 1'b1;
         if (i == 8) `CHK("ready when full", ready, 1'b0)  // eight queued sets stall the producer
         t = 0;
         while (ready !== 1'b1) begin
            @(negedge clk);
            t++;
            if (t > 3000) begin
               errors++;
               end_of_test();
            end
         end
         @(negedge clk);
      end
      valid = 1'b0;
   endtask : push_all

   // watches one whole frame from its first edge; the length comes from the slot count
   task automatic frame(input logic [79:0] st);
      int s, gates, bad_g, bad_b, bad_q, bad_n;
      logic q1, q2;
      s = int'(slots);
      gates = 0;
      bad_g = 0;
      bad_b = 0;
      bad_q = 0;
      bad_n = 0;
      q1 = 1'b0;
      q2 = 1'b0;
      dac.clear();
      for (int c = 0; c < s * SLOT_CYCLES; c++) begin
         @(negedge clk);
         #1;
         gates += gclk;
         bad_g += (gclk !== ((c % SLOT_CYCLES < GATE_ON_CYCLES) && (c / SLOT_CYCLES < GATED_SLOTS || s == MAX_SLOTS)));
         bad_b += (bclk !== (c % BIT_CYCLES >= HALF_BIT_CYCLES));
         bad_n += (slot_no !== 5'(slot_num(c / SLOT_CYCLES, s)));
         if (c >= 2) bad_q += (qclk === q2);  // two high, two low: never equal two cycles apart
         q2 = q1;
         q1 = qclk;
         #10 bad_g += (gclk !== 1'b0);  // each pulse ends with the oscillator's high half
      end
      `CHK("bit count", dac.nbits, 2 * s)
      `CHK("main data", dac.main_sh, exp_bits(st, 79, 0))
      `CHK("effects data", dac.fx_sh, exp_bits(st, 39, 0))
      `CHK("word clock", dac.lr_sh, exp_bits(st, 79, 1))
      `CHK("gated pulses", gates, (s == MAX_SLOTS) ? 2048 : 1024)
      `CHK("gated pattern", bad_g, 0)
      `CHK("bit clock", bad_b, 0)
      `CHK("quarter clock", bad_q, 0)
      `CHK("slot order", bad_n, 0)
   endtask : frame

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      do_reset(1'b1, 16, 3);
      // every format and slot count class; format 1 with 24 slots sends all ones to expose padding
      for (int i = 0; i < 8; i++) begin
         sets[0] = (i == 4) ? {80{1'b1}} : 80'({$random(seed), $random(seed), $random(seed)});
         do_reset(cf[i], cs[i], 2);
         fork
            push_all(1);
            frame(80'h0);
         join
         frame(sets[0]);
      end
      // fill the fifo until it refuses, then drain one set per frame down to a silent frame
      for (int i = 0; i < 9; i++) sets[i] = 80'({$random(seed), $random(seed), $random(seed)});
      do_reset(1'b1, 16, 2);
      fork
         push_all(9);
         begin
            frame(80'h0);
            frame(sets[0]);
         end
      join
      for (int i = 1; i < 9; i++) frame(sets[i]);
      frame(80'h0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire

// ===== core/sample_fifo.sv
// synchronous FIFO holding queued stereo sample sets ahead of the serialiser
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
   import synth_audio_pkg::*;
#(
   parameter int WIDTH = 80,
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // stream ports
   sample_fifo_if.store q
);
   localparam int AW = $clog2(DEPTH);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_s;

   fifo_state_s st_ff;
   fifo_state_s nxt_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic do_push;
   logic do_pop;

   // flags from the extra pointer bit; full stalls the writer
   assign empty = (st_ff.wr == st_ff.rd);
   assign full = (st_ff.wr[AW] != st_ff.rd[AW]) && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
   assign q.push_ready = !full;
   assign q.pop_valid = !empty;
   assign q.pop_data = mem[st_ff.rd[AW-1:0]];
   assign do_push = q.push_valid && !full;
   assign do_pop = q.pop_ready && !empty;

   // pointer update
   always_comb begin
      nxt_st = st_ff;
      if (do_push) begin
         nxt_st.wr = st_ff.wr + 1'b1;
      end
      if (do_pop) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // storage has no reset; only written entries are ever read
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[st_ff.wr[AW-1:0]] <= q.push_data;
      end
   end

   a_fifo_count_ok: assert property (@(posedge clk_in) disable iff (srst_in)
      (st_ff.wr - st_ff.rd) <= (AW+1)'(DEPTH))
      else $error("fifo holds more entries than its depth");

endmodule : sample_fifo
`default_nettype wire

// ===== core/sample_fifo_if.sv
// interface carrying the sample stream between the output block and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface sample_fifo_if #(parameter int WIDTH = 80);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;

   // fifo side
   modport store (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
   // block side
   modport user (output push_valid, output push_data, input push_ready,
                 input pop_valid, input pop_data, output pop_ready);
endinterface : sample_fifo_if
`default_nettype wire

// ===== core/synth_audio_pkg.sv
// constants and types shared by the serial audio output block and its sample FIFO
//
// Function
// [R1] one bit clock and one word clock time both main and effects data outputs
// [R2] a format select input picks one of two word clock formats
// [R3] format 0: 16/18/20 bit words by slot count; format 1: always 16 bits
// [R4] each frame holds exactly two bit clock periods per synthesis slot in use
// [R5] bit positions past the word width are sent as zeros
// [R6] left MSB goes out in slot 0, right MSB in slot 8
// [R7] extra slot numbers are inserted in pairs after slot 7 and after slot 15
// [R8] the slot count is always even so left and right padding match
// [R9] the divided clock output runs at a quarter of the oscillator rate
// [R10] the divided clock output stays low while reset is applied
// [R11] each gated clock pulse has the oscillator period
// [R12] below 32 slots the gated clock runs only in the first 16 slot periods
// [R13] with 32 slots the gated clock runs in all 32 slot periods
// [R14] a slot period is 68 cycles: 64 gated on, then 4 held off
// [R15] the gated clock keeps running while reset is applied
// [R16] the controller holds reset until the oscillator has settled
// [R17] apart from the gated clock everything stays idle during reset
// [R18] word clock has one level for the left half, the other for the right
// [R19] data goes MSB first, changes on the falling bit clock edge, sampled on rising
// [R20] one bit period is half a slot period, 34 oscillator cycles
package synth_audio_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int OSC_HZ = 50_000_000;
   localparam int SLOT_CYCLES = 68;
   localparam int GATE_ON_CYCLES = 64;
   localparam int GATE_OFF_CYCLES = SLOT_CYCLES - GATE_ON_CYCLES;
   localparam int BIT_CYCLES = SLOT_CYCLES / 2;
   localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

   // ****************************************
   // frame layout
   // ****************************************
   localparam int MIN_SLOTS = 16;
   localparam int MAX_SLOTS = 32;
   localparam int GATED_SLOTS = 16;
   localparam int RIGHT_MSB_SLOT = 8;
   localparam int LEFT_EXTRA_BASE = 16;
   localparam int RIGHT_EXTRA_BASE = 24;
   localparam int WORD_W_STD = 16;
   localparam int WORD_W_MID = 18;
   localparam int WORD_W_MAX = 20;
   localparam int SAMPLE_W_DEF = 20;
   localparam int FIFO_DEPTH_DEF = 8;
   localparam int CHANNELS = 4;

   typedef logic [6:0] cyc_t;
   typedef logic [4:0] pos_t;
   typedef logic [5:0] cnt_t;

   localparam cyc_t SLOT_LAST = cyc_t'(SLOT_CYCLES - 1);
   localparam cyc_t GATE_ON_C = cyc_t'(GATE_ON_CYCLES);
   localparam cyc_t BIT_C = cyc_t'(BIT_CYCLES);
   localparam cyc_t HALF_BIT_C = cyc_t'(HALF_BIT_CYCLES);
   localparam cnt_t MIN_SLOTS_C = cnt_t'(MIN_SLOTS);
   localparam cnt_t MAX_SLOTS_C = cnt_t'(MAX_SLOTS);
   localparam cnt_t SLOTS_RESET = MIN_SLOTS_C;

endpackage : synth_audio_pkg

// ===== core/synth_serial_audio_out.sv
// serial audio output, word and bit clocks, quarter rate clock and gated effects clock
`timescale 1ns/1ps
`default_nettype none
module synth_serial_audio_out
   import synth_audio_pkg::*;
#(
   parameter int SAMPLE_W = SAMPLE_W_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic SRST_IN,
   // configuration
   input wire logic SERIAL_FORMAT_SELECT_IN,
   input wire logic [5:0] SLOT_COUNT_IN,
   // sample stream, one set of four channels per frame
   input wire logic SAMPLE_VALID_IN,
   output logic SAMPLE_READY_OUT,
   input wire logic [SAMPLE_W-1:0] MAIN_LEFT_IN,
   input wire logic [SAMPLE_W-1:0] MAIN_RIGHT_IN,
   input wire logic [SAMPLE_W-1:0] EFFECTS_LEFT_IN,
   input wire logic [SAMPLE_W-1:0] EFFECTS_RIGHT_IN,
   // serial link
   output logic SERIAL_BIT_CLOCK_OUT,
   output logic LR_WORD_CLOCK_OUT,
   output logic MAIN_AUDIO_OUT,
   output logic EFFECTS_AUDIO_OUT,
   // clock outputs and status
   output logic QUARTER_RATE_CLOCK_OUT,
   output logic GATED_EFFECTS_CLOCK_OUT,
   output logic [4:0] CURRENT_SLOT_OUT
);
   localparam int SET_W = CHANNELS * SAMPLE_W;
   // the longest frame fits this counter; the counter only feeds the frame length check
   localparam int FRAME_CNT_W = $clog2(MAX_SLOTS * SLOT_CYCLES + 1);
   // bit clock rise after a bit starts, held here so the property delay is a local constant
   localparam int HALF_BIT_DLY = HALF_BIT_CYCLES;

   // ****************************************
   // elaboration checks
   // ****************************************
   if (SAMPLE_W < WORD_W_MAX) begin : g_bad_width
      $error("sample width must cover the widest serial word");
   end
   if (FIFO_DEPTH < 2) begin : g_bad_fifo_depth
      $error("at least two sample sets must queue ahead of the serialiser");
   end

   typedef struct packed {
      logic in_reset;
      logic fmt;
      cyc_t cyc;
      pos_t pos;
      cnt_t slots;
      logic [SET_W-1:0] cur;
      logic [1:0] div;
      logic gate;
      logic bclk;
      logic lr;
      logic main;
      logic fx;
      pos_t slot_no;
      logic [FRAME_CNT_W-1:0] fcnt;
   } out_state_s;

   localparam out_state_s RESET_ST = '{in_reset: 1'b1, fmt: 1'b0, cyc: '0, pos: '0, slots: SLOTS_RESET,
      cur: '0, div: '0, gate: 1'b1, bclk: 1'b0, lr: 1'b0, main: 1'b0, fx: 1'b0, slot_no: '0, fcnt: '0};

   out_state_s st_ff;
   out_state_s nxt_st;
   logic frame_start;
   cnt_t nxt_fbit;
   cnt_t nxt_early;
   cyc_t nxt_phase;

   sample_fifo_if #(.WIDTH(SET_W)) fq ();

   // ****************************************
   // helper functions
   // ****************************************

   // out-of-range counts are clamped and an odd count is rounded down
   function automatic cnt_t clamp_slots(input logic [5:0] req);
      if (req < MIN_SLOTS_C) begin
         return MIN_SLOTS_C;
      end
      if (req > MAX_SLOTS_C) begin
         return MAX_SLOTS_C;
      end
      return {req[5:1], 1'b0}; // [R8]
   endfunction : clamp_slots

   function automatic cnt_t word_width(input logic fmt, input cnt_t n);
      if (fmt || n == cnt_t'(WORD_W_STD)) begin
         return cnt_t'(WORD_W_STD); // [R3]
      end
      if (n == cnt_t'(WORD_W_MID)) begin
         return cnt_t'(WORD_W_MID); // [R3]
      end
      return cnt_t'(WORD_W_MAX); // [R3]
   endfunction : word_width

   // bit index across the frame: two bits per slot
   function automatic cnt_t frame_bit(input cyc_t c, input pos_t p);
      return cnt_t'({p, 1'b0}) + cnt_t'(c >= BIT_C); // [R4]
   endfunction : frame_bit

   // bit of one channel pair for a frame bit position, msb first, zero padded
   function automatic logic serial_bit(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r,
                                       input cnt_t fb, input cnt_t n, input logic fmt);
      logic half;
      cnt_t idx;
      logic [SAMPLE_W-1:0] s;
      half = (fb >= n);
      idx = half ? cnt_t'(fb - n) : fb;
      s = half ? r : l;
      if (idx < word_width(fmt, n)) begin
         return s[SAMPLE_W-1-int'(idx)]; // [R19] [R6]
      end
      return 1'b0; // [R5]
   endfunction : serial_bit

   // printed slot number for a position: extra pairs follow slot 7 and slot 15
   function automatic pos_t slot_label(input pos_t p, input cnt_t n);
      int extra;
      int pi;
      extra = (int'(n) - MIN_SLOTS) / 2;
      pi = int'(p);
      if (pi < RIGHT_MSB_SLOT) begin
         return p; // [R7]
      end
      if (pi < RIGHT_MSB_SLOT + extra) begin
         return pos_t'(LEFT_EXTRA_BASE + pi - RIGHT_MSB_SLOT); // [R7]
      end
      if (pi < MIN_SLOTS + extra) begin
         return pos_t'(pi - extra); // [R7]
      end
      return pos_t'(RIGHT_EXTRA_BASE + pi - MIN_SLOTS - extra); // [R7]
   endfunction : slot_label

   function automatic logic gate_on(input cyc_t c, input pos_t p, input cnt_t n);
      return (c < GATE_ON_C) && (n == MAX_SLOTS_C || p < pos_t'(GATED_SLOTS)); // [R12] [R13] [R14]
   endfunction : gate_on

   // ****************************************
   // sample buffer
   // ****************************************
   assign fq.push_valid = SAMPLE_VALID_IN;
   assign fq.push_data = {MAIN_LEFT_IN, MAIN_RIGHT_IN, EFFECTS_LEFT_IN, EFFECTS_RIGHT_IN};
   assign SAMPLE_READY_OUT = fq.push_ready;
   assign fq.pop_ready = frame_start && !SRST_IN;

   sample_fifo #(.WIDTH(SET_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .q(fq.store)
   );

   // ****************************************
   // frame timing and serialiser
   // ****************************************

   // a new frame begins after the last cycle of the last slot, or on reset release
   assign frame_start = st_ff.in_reset || (st_ff.cyc == SLOT_LAST && st_ff.pos == pos_t'(st_ff.slots - 1'b1));

   // every output but ready and the gated clock is computed for the coming cycle so that it leaves a flop
   always_comb begin
      nxt_st = st_ff;
      nxt_st.in_reset = 1'b0;
      nxt_st.div = st_ff.div + 2'b01; // [R9]
      // free count of cycles since the frame began, independent of the slot position
      nxt_st.fcnt = st_ff.fcnt + 1'b1;
      if (frame_start) begin
         // slot count and format only change on a frame boundary, so a frame is never torn
         nxt_st.cyc = '0;
         nxt_st.pos = '0;
         nxt_st.fcnt = '0;
         nxt_st.slots = clamp_slots(SLOT_COUNT_IN); // [R8]
         nxt_st.fmt = SERIAL_FORMAT_SELECT_IN; // [R2]
         // an empty queue sends silence rather than repeating stale data
         nxt_st.cur = fq.pop_valid ? fq.pop_data : '0;
      end else if (st_ff.cyc == SLOT_LAST) begin
         nxt_st.cyc = '0; // [R14]
         nxt_st.pos = st_ff.pos + 1'b1; // [R4]
      end else begin
         nxt_st.cyc = st_ff.cyc + 1'b1;
      end
      nxt_fbit = frame_bit(nxt_st.cyc, nxt_st.pos);
      nxt_early = (nxt_fbit == cnt_t'({nxt_st.slots, 1'b0} - 1'b1)) ? '0 : cnt_t'(nxt_fbit + 1'b1);
      nxt_phase = (nxt_st.cyc >= BIT_C) ? cyc_t'(nxt_st.cyc - BIT_C) : nxt_st.cyc;
      nxt_st.bclk = (nxt_phase >= HALF_BIT_C); // [R20] [R1]
      // format 0 leads the channel change by one bit, format 1 aligns it with the msb
      nxt_st.lr = nxt_st.fmt ? (nxt_fbit >= nxt_st.slots) : (nxt_early >= nxt_st.slots); // [R18] [R2]
      nxt_st.main = serial_bit(nxt_st.cur[4*SAMPLE_W-1 -: SAMPLE_W], nxt_st.cur[3*SAMPLE_W-1 -: SAMPLE_W],
                               nxt_fbit, nxt_st.slots, nxt_st.fmt); // [R1]
      nxt_st.fx = serial_bit(nxt_st.cur[2*SAMPLE_W-1 -: SAMPLE_W], nxt_st.cur[SAMPLE_W-1:0],
                             nxt_fbit, nxt_st.slots, nxt_st.fmt); // [R1]
      nxt_st.gate = gate_on(nxt_st.cyc, nxt_st.pos, nxt_st.slots);
      nxt_st.slot_no = slot_label(nxt_st.pos, nxt_st.slots);
      if (SRST_IN) begin
         nxt_st = RESET_ST; // [R17] [R10] [R15]
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      st_ff <= nxt_st;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign SERIAL_BIT_CLOCK_OUT = st_ff.bclk;
   assign LR_WORD_CLOCK_OUT = st_ff.lr;
   assign MAIN_AUDIO_OUT = st_ff.main;
   assign EFFECTS_AUDIO_OUT = st_ff.fx;
   assign QUARTER_RATE_CLOCK_OUT = st_ff.div[1]; // [R9]
   assign CURRENT_SLOT_OUT = st_ff.slot_no;
   // the gate flop changes on the rising edge, so pulses taken in the low half cannot glitch
   assign GATED_EFFECTS_CLOCK_OUT = st_ff.gate & ~REF_CLK_IN; // [R11] [R15]

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);

   // building blocks of the clock output properties
   sequence s_quarter_high;
      QUARTER_RATE_CLOCK_OUT [*2];
   endsequence
   sequence s_quarter_low;
      !QUARTER_RATE_CLOCK_OUT [*2];
   endsequence
   sequence s_gate_gap;
      !st_ff.gate [*4];
   endsequence

   // reset behaviour is checked with the reset itself as trigger, so these are never disabled
   a_quarter_reset_low: assert property (@(posedge REF_CLK_IN) disable iff (1'b0) // [R10]
      SRST_IN |=> !QUARTER_RATE_CLOCK_OUT ##0 st_ff.gate)
      else $error("quarter clock not held low or gated clock stopped in reset");
   a_quarter_period: assert property ($rose(QUARTER_RATE_CLOCK_OUT) |-> s_quarter_high ##1 s_quarter_low) // [R9]
      else $error("quarter clock is not two high and two low cycles");
   // gated clock shape per slot and per frame
   a_gate_off_gap: assert property (st_ff.cyc == GATE_ON_C && !st_ff.in_reset |-> s_gate_gap ##1 st_ff.cyc == '0) // [R14]
      else $error("gated clock gap is not four cycles ending the slot");
   a_gate_idle_slots: assert property (!st_ff.in_reset && st_ff.slots != MAX_SLOTS_C // [R12]
      && st_ff.pos >= pos_t'(GATED_SLOTS) |-> !st_ff.gate)
      else $error("gated clock active beyond slot sixteen");
   a_gate_full_frame: assert property (!st_ff.in_reset && st_ff.slots == MAX_SLOTS_C // [R13]
      && st_ff.cyc == '0 |-> st_ff.gate [*8])
      else $error("gated clock missing in a thirty-two slot frame");
   // channel placement inside the frame
   a_left_msb_slot: assert property (!st_ff.in_reset && st_ff.pos == '0 && st_ff.cyc == '0 // [R6]
      |-> MAIN_AUDIO_OUT == st_ff.cur[4*SAMPLE_W-1] && CURRENT_SLOT_OUT == '0)
      else $error("left msb not sent in slot zero");
   a_right_msb_slot: assert property (!st_ff.in_reset && st_ff.cyc == '0 // [R7]
      && cnt_t'({st_ff.pos, 1'b0}) == st_ff.slots |-> CURRENT_SLOT_OUT == pos_t'(RIGHT_MSB_SLOT)
      && EFFECTS_AUDIO_OUT == st_ff.cur[SAMPLE_W-1])
      else $error("right msb not sent in slot eight");
   a_pad_zero: assert property (!st_ff.in_reset && st_ff.slots > cnt_t'(WORD_W_MAX) // [R5]
      && frame_bit(st_ff.cyc, st_ff.pos) == cnt_t'(WORD_W_MAX) |-> !MAIN_AUDIO_OUT && !EFFECTS_AUDIO_OUT)
      else $error("padding bit is not zero");
   // bit clock and data timing
   a_bit_clock_shape: assert property (!st_ff.in_reset && (st_ff.cyc == '0 || st_ff.cyc == BIT_C) // [R20]
      |-> !SERIAL_BIT_CLOCK_OUT ##HALF_BIT_DLY SERIAL_BIT_CLOCK_OUT)
      else $error("bit clock is not seventeen low then high");
   a_data_stable_rise: assert property ($rose(SERIAL_BIT_CLOCK_OUT) |-> $stable(MAIN_AUDIO_OUT)) // [R19]
      else $error("data changed on the rising bit clock edge");
   a_word_clock_left: assert property (!st_ff.in_reset && st_ff.fmt && st_ff.pos == '0 |-> !LR_WORD_CLOCK_OUT) // [R18]
      else $error("word clock not low in the left half");
   // frame length measured by the free cycle counter rather than by the slot position
   a_frame_length: assert property (frame_start && !st_ff.in_reset // [R4]
      |-> st_ff.cyc == SLOT_LAST && int'(st_ff.fcnt) + 1 == int'(st_ff.slots) * SLOT_CYCLES)
      else $error("frame does not hold the programmed slot count");
   a_slot_step: assert property (!st_ff.in_reset && !frame_start && st_ff.cyc == SLOT_LAST // [R4]
      |=> st_ff.pos == $past(st_ff.pos) + 1'b1 && st_ff.cyc == '0)
      else $error("slot position did not advance by one");
   a_fx_stable_rise: assert property ($rose(SERIAL_BIT_CLOCK_OUT) |-> $stable(EFFECTS_AUDIO_OUT)) // [R19]
      else $error("effects data changed on the rising bit clock edge");
   // format 0 raises the word clock for the last left bit and drops it for the last bit of the frame
   sequence s_last_left_bit;
      !st_ff.in_reset && !st_ff.fmt && st_ff.cyc == BIT_C && cnt_t'({st_ff.pos, 1'b1}) + 1'b1 == st_ff.slots;
   endsequence
   a_word_clock_early: assert property (s_last_left_bit |-> LR_WORD_CLOCK_OUT) // [R18]
      else $error("word clock not raised one bit ahead of the right channel");
   a_word_clock_wrap: assert property (frame_start && !st_ff.in_reset && !st_ff.fmt // [R18]
      |-> !LR_WORD_CLOCK_OUT)
      else $error("word clock not back to left for the last bit of the frame");
   a_word_clock_right: assert property (!st_ff.in_reset && st_ff.fmt && st_ff.cyc == '0 // [R18]
      && cnt_t'({st_ff.pos, 1'b0}) == st_ff.slots |-> LR_WORD_CLOCK_OUT)
      else $error("word clock not high at the right msb");
   // the serial link rests while reset is applied
   a_link_idle_reset: assert property (@(posedge REF_CLK_IN) disable iff (1'b0) // [R17]
      SRST_IN |=> !SERIAL_BIT_CLOCK_OUT && !LR_WORD_CLOCK_OUT && !MAIN_AUDIO_OUT && !EFFECTS_AUDIO_OUT)
      else $error("serial link not idle in reset");

endmodule : synth_serial_audio_out
`default_nettype wire
